// ### inc/dma_pkg.sv
package dma_pkg;
    // Channel count and per-channel register window
    localparam int          CH_NUM      = 8;
    localparam logic [4:0]  OFS_CTL     = 5'h00;
    localparam logic [4:0]  OFS_REQ     = 5'h04;
    localparam logic [4:0]  OFS_STA     = 5'h08;
    localparam logic [4:0]  OFS_STB     = 5'h0C;
    localparam logic [4:0]  OFS_PAD     = 5'h10;
    localparam logic [4:0]  OFS_CNT     = 5'h14;
    // Shared status registers
    localparam logic [8:0]  OFS_COLL    = 9'h100;
    localparam logic [8:0]  OFS_PPST    = 9'h104;
    // Control field positions
    localparam int          B_EN        = 15;
    localparam int          B_SIZE      = 14;
    localparam int          B_DIR       = 13;
    localparam int          B_HALF      = 12;
    localparam int          B_NULL_WRITE_SELECT     = 11;
    localparam int          B_AM        = 4;
    localparam int          B_MODE      = 0;
    localparam int          B_FORCE     = 15;
    localparam int          CNT_W       = 10;
    localparam logic [15:0] CTL_MASK    = 16'hF833;
    localparam logic [15:0] REQ_MASK    = 16'h007F;
    // Reset values
    localparam logic [15:0] RST_REG     = 16'h0000;
    localparam logic [3:0]  RST_LAST    = 4'hF;
    localparam logic [1:0]  RESP_OKAY   = 2'b00;
    localparam logic [1:0]  RESP_SLVERR = 2'b10;
    // Transfer engine states
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_RD   = 4'b0010,
        ST_WR   = 4'b0100,
        ST_NUL  = 4'b1000
    } eng_st_t;
endpackage

// ### logic/periph_dma.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// RULE1: eight channels, each own register set
// RULE2: transfers use dedicated transfer bus ports
// RULE3: control register fields, reset zero
// RULE4: size bit one means byte transfers
// RULE5: direction one reads RAM, writes peripheral
// RULE6: addressing mode post-inc, fixed, peripheral
// RULE7: irq at block end or half block
// RULE8: one-shot stops, auto-repeat restarts
// RULE9: ping-pong alternates start addresses
// RULE10: start address reads return live pointer
// RULE11: fixed priority arbitration between channels
// RULE12: start by peripheral request or force
// RULE13: seven bit request code selects trigger
// RULE14: software loads peripheral data address
// RULE15: ten bit transfer count per channel
// RULE16: shared RAM and peripheral collision flags
// RULE17: status shows last channel, ping-pong
// RULE18: buffers must live in DMA RAM
// RULE19: irq flag, enable, priority kept outside
// RULE20: block is count plus one transfers
// RULE21: force does one transfer, hardware clears
// RULE22: lower numbered channel wins ties
// RULE23: one-shot clears enable at block end
module periph_dma
    import dma_pkg::*;
#(
    parameter int NCH = dma_pkg::CH_NUM
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [8:0]  s_awaddr,
    input  wire logic        s_awvalid,
    output logic             s_awready,
    input  wire logic [31:0] s_wdata,
    input  wire logic [3:0]  s_wstrb,
    input  wire logic        s_wvalid,
    output logic             s_wready,
    output logic [1:0]       s_bresp,
    output logic             s_bvalid,
    input  wire logic        s_bready,
    input  wire logic [8:0]  s_araddr,
    input  wire logic        s_arvalid,
    output logic             s_arready,
    output logic [31:0]      s_rdata,
    output logic [1:0]       s_rresp,
    output logic             s_rvalid,
    input  wire logic        s_rready,
    input  wire logic [127:0] req_lines,
    input  wire logic [15:0] pind_addr,
    input  wire logic        cpu_ram_collide,
    input  wire logic        cpu_per_collide,
    output logic             xb_req,
    output logic             xb_we,
    output logic             xb_ram,
    output logic             xb_byte,
    output logic [15:0]      xb_addr,
    output logic [15:0]      xb_wdata,
    input  wire logic        xb_ack,
    input  wire logic [15:0] xb_rdata,
    output logic [7:0]       chan_irq
);
    if (NCH < 1 || NCH > CH_NUM) begin : g_chk
        $error("NCH out of range");
    end

    // Whole block state in one record
    typedef struct packed {
        eng_st_t                 st;
        logic [2:0]              cur;       // Channel being served
        logic [3:0]              last;      // Last granted channel
        logic [7:0][15:0]        ctl;
        logic [7:0][15:0]        req;
        logic [7:0][15:0]        sta;
        logic [7:0][15:0]        stb;
        logic [7:0][15:0]        pad;
        logic [7:0][CNT_W-1:0]   cnt;
        logic [7:0][15:0]        ptr;       // Live RAM pointer
        logic [7:0][CNT_W-1:0]   idx;       // Transfers done
        logic [7:0]              pend;
        logic [7:0]              pp;        // Buffer in use
        logic [15:0]             coll;
        logic [127:0]            req_q;
        logic                    awready;
        logic                    wready;
        logic [8:0]              awaddr;
        logic [31:0]             wdata;
        logic [3:0]              wstrb;
        logic                    bvalid;
        logic [1:0]              bresp;
        logic                    arready;
        logic                    rvalid;
        logic [31:0]             rdata;
        logic [1:0]              rresp;
        logic                    xreq;
        logic                    xwe;
        logic                    xram;
        logic                    xbyte;
        logic [15:0]             xaddr;
        logic [15:0]             xwdata;
        logic [7:0]              irq;
    } state_t;

    state_t s_r;
    state_t s_nxt;

    // Lowest set bit wins
    function automatic logic [2:0] pick(input logic [7:0] v);
        pick = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (v[i]) begin
                pick = 3'(i);
            end
        end
    endfunction

    // Byte lane merge of a 16-bit register
    function automatic logic [15:0] merge(input logic [15:0] o,
                                          input logic [31:0] d,
                                          input logic [3:0]  b);
        merge = {b[1] ? d[15:8] : o[15:8], b[0] ? d[7:0] : o[7:0]};
    endfunction

    // Address decode: channel window below the shared block
    function automatic logic ch_hit(input logic [8:0] a);
        ch_hit = !a[8] && (32'(a[7:5]) < NCH) && a[1:0] == 2'b00
                 && a[4:2] <= 3'h5;
    endfunction

    logic [7:0] want;
    logic       fin;

    // Channels asking for service
    always_comb begin
        want = '0;
        for (int c = 0; c < NCH; c++) begin
            want[c] = s_r.ctl[c][B_EN] && (s_r.pend[c] || s_r.req[c][B_FORCE]);
        end
    end

    // Next state
    always_comb begin
        logic [2:0]  c;
        logic [2:0]  wc;
        logic [15:0] rv;
        logic [15:0] ra;
        logic        hit;
        c   = s_r.cur;
        wc  = s_r.awaddr[7:5];
        rv  = '0;
        ra  = '0;
        hit = 1'b0;
        fin = 1'b0;
        s_nxt = s_r;
        s_nxt.irq = '0;
        s_nxt.req_q = req_lines;

        // Write address and data, taken in either order
        if (s_awvalid && s_r.awready) begin
            s_nxt.awaddr  = s_awaddr;
            s_nxt.awready = 1'b0;
        end
        if (s_wvalid && s_r.wready) begin
            s_nxt.wdata  = s_wdata;
            s_nxt.wstrb  = s_wstrb;
            s_nxt.wready = 1'b0;
        end
        // Both halves held: commit and respond
        if (!s_r.awready && !s_r.wready && !s_r.bvalid) begin
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp  = RESP_OKAY;
            if (ch_hit(s_r.awaddr)) begin
                unique case ({s_r.awaddr[4:2], 2'b00})
                    OFS_CTL: begin
                        s_nxt.ctl[wc] = merge(s_r.ctl[wc], s_r.wdata,
                                              s_r.wstrb) & CTL_MASK; // see RULE3
                        // Enabling arms the pointer at the primary buffer
                        if (!s_r.ctl[wc][B_EN] && s_nxt.ctl[wc][B_EN]) begin
                            s_nxt.ptr[wc] = s_r.sta[wc];
                            s_nxt.idx[wc] = '0;
                            s_nxt.pp[wc]  = 1'b0;
                        end
                    end
                    OFS_REQ: begin
                        // Force can be set, never cleared by software
                        s_nxt.req[wc] = (merge(s_r.req[wc], s_r.wdata,
                                         s_r.wstrb) & REQ_MASK)
                                        | (s_r.req[wc] & 16'h8000)
                                        | ((s_r.wstrb[1] && s_r.wdata[B_FORCE])
                                           ? 16'h8000 : 16'h0000); // see RULE21
                    end
                    OFS_STA: s_nxt.sta[wc] = merge(s_r.sta[wc], s_r.wdata,
                                                   s_r.wstrb); // see RULE10
                    OFS_STB: s_nxt.stb[wc] = merge(s_r.stb[wc], s_r.wdata,
                                                   s_r.wstrb);
                    OFS_PAD: s_nxt.pad[wc] = merge(s_r.pad[wc], s_r.wdata,
                                                   s_r.wstrb); // see RULE14
                    default: s_nxt.cnt[wc] = CNT_W'(merge({6'h00, s_r.cnt[wc]},
                                             s_r.wdata, s_r.wstrb)); // see RULE15
                endcase
            end else if (s_r.awaddr == OFS_COLL) begin
                // Write one to clear; a fresh hit below still wins
                s_nxt.coll = s_r.coll & ~merge(16'h0000, s_r.wdata, s_r.wstrb);
            end else if (s_r.awaddr != OFS_PPST) begin
                s_nxt.bresp = RESP_SLVERR;
            end
        end
        if (s_r.bvalid && s_bready) begin
            s_nxt.bvalid  = 1'b0;
            s_nxt.awready = 1'b1;
            s_nxt.wready  = 1'b1;
        end

        // Register reads
        if (ch_hit(s_araddr)) begin
            hit = 1'b1;
            unique case ({s_araddr[4:2], 2'b00})
                OFS_CTL: rv = s_r.ctl[s_araddr[7:5]];
                OFS_REQ: rv = s_r.req[s_araddr[7:5]];
                OFS_STA: rv = s_r.ptr[s_araddr[7:5]]; // see RULE10
                OFS_STB: rv = s_r.ptr[s_araddr[7:5]];
                OFS_PAD: rv = s_r.pad[s_araddr[7:5]];
                default: rv = {6'h00, s_r.cnt[s_araddr[7:5]]};
            endcase
        end else if (s_araddr == OFS_COLL) begin
            hit = 1'b1;
            rv  = s_r.coll; // see RULE16
        end else if (s_araddr == OFS_PPST) begin
            hit = 1'b1;
            rv  = {4'h0, s_r.last, s_r.pp}; // see RULE17
        end
        if (s_arvalid && s_r.arready) begin
            s_nxt.arready = 1'b0;
            s_nxt.rvalid  = 1'b1;
            s_nxt.rdata   = {16'h0000, rv};
            s_nxt.rresp   = hit ? RESP_OKAY : RESP_SLVERR;
        end
        if (s_r.rvalid && s_rready) begin
            s_nxt.rvalid  = 1'b0;
            s_nxt.arready = 1'b1;
        end

        // Transfer engine on its own bus; no CPU cycles are taken
        ra = s_r.ctl[c][B_AM+1] ? pind_addr : s_r.ptr[c]; // see RULE6
        unique case (s_r.st)
            ST_IDLE: begin
                if (|want) begin
                    c = pick(want); // see RULE11 see RULE22
                    ra = s_r.ctl[c][B_AM+1] ? pind_addr : s_r.ptr[c];
                    s_nxt.cur   = c;
                    s_nxt.last  = {1'b0, c};
                    s_nxt.xreq  = 1'b1; // see RULE2
                    s_nxt.xwe   = 1'b0;
                    s_nxt.xbyte = s_r.ctl[c][B_SIZE]; // see RULE4
                    s_nxt.xram  = s_r.ctl[c][B_DIR]; // see RULE5
                    s_nxt.xaddr = s_r.ctl[c][B_DIR] ? ra : s_r.pad[c];
                    s_nxt.st    = ST_RD;
                end
            end
            ST_RD: begin
                if (xb_ack) begin
                    s_nxt.xwdata = s_r.xbyte ? {8'h00, xb_rdata[7:0]}
                                             : xb_rdata;
                    s_nxt.xwe   = 1'b1;
                    s_nxt.xram  = !s_r.ctl[c][B_DIR];
                    s_nxt.xaddr = s_r.ctl[c][B_DIR] ? s_r.pad[c] : ra;
                    s_nxt.st    = ST_WR;
                end
            end
            ST_WR: begin
                if (xb_ack) begin
                    // Collision flags for the active channel
                    if (s_r.xram && cpu_ram_collide) begin
                        s_nxt.coll[c] = 1'b1; // see RULE16
                    end
                    if (!s_r.xram && cpu_per_collide) begin
                        s_nxt.coll[8+c] = 1'b1;
                    end
                    if (s_r.ctl[c][B_NULL_WRITE_SELECT] && !s_r.ctl[c][B_DIR]) begin
                        s_nxt.xram   = 1'b0;
                        s_nxt.xaddr  = s_r.pad[c];
                        s_nxt.xwdata = 16'h0000;
                        s_nxt.st     = ST_NUL;
                    end else begin
                        fin = 1'b1;
                    end
                end
            end
            ST_NUL: begin
                if (xb_ack) begin
                    if (cpu_per_collide) begin
                        s_nxt.coll[8+c] = 1'b1;
                    end
                    fin = 1'b1;
                end
            end
        endcase

        // One transfer finished: advance pointer and count
        if (fin) begin
            s_nxt.st   = ST_IDLE;
            s_nxt.xreq = 1'b0;
            s_nxt.xwe  = 1'b0;
            s_nxt.pend[c] = 1'b0;
            s_nxt.req[c][B_FORCE] = 1'b0; // see RULE21 see RULE12
            if (s_r.ctl[c][B_AM+1:B_AM] == 2'b00) begin
                s_nxt.ptr[c] = s_r.ptr[c] + (s_r.ctl[c][B_SIZE] ? 16'h0001
                                                                : 16'h0002);
            end
            if (s_r.idx[c] == s_r.cnt[c]) begin
                // Block holds count plus one transfers
                s_nxt.idx[c] = '0; // see RULE20
                s_nxt.irq[c] = !s_r.ctl[c][B_HALF]; // see RULE7
                s_nxt.pp[c]  = s_r.pp[c] ^ s_r.ctl[c][B_MODE+1]; // see RULE9
                s_nxt.ptr[c] = s_nxt.pp[c] ? s_r.stb[c] : s_r.sta[c]; // see RULE8
                if (s_r.ctl[c][B_MODE]) begin
                    s_nxt.ctl[c][B_EN] = 1'b0; // see RULE23
                end
            end else begin
                s_nxt.idx[c] = s_r.idx[c] + 1'b1;
                s_nxt.irq[c] = s_r.ctl[c][B_HALF]
                               && s_r.idx[c] == (s_r.cnt[c] >> 1); // see RULE7
            end
        end

        // Request edges latch pending; a set beats the clear above
        for (int k = 0; k < NCH; k++) begin
            if (s_r.ctl[k][B_EN]
                && req_lines[s_r.req[k][6:0]]
                && !s_r.req_q[s_r.req[k][6:0]]) begin
                s_nxt.pend[k] = 1'b1; // see RULE13 see RULE12 see RULE1
            end
        end
    end

    // State register, synchronous reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r         <= '0;
            s_r.st      <= ST_IDLE;
            s_r.last    <= RST_LAST;
            s_r.awready <= 1'b1;
            s_r.wready  <= 1'b1;
            s_r.arready <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Ports straight from the state register
    assign s_awready = s_r.awready;
    assign s_wready  = s_r.wready;
    assign s_bresp   = s_r.bresp;
    assign s_bvalid  = s_r.bvalid;
    assign s_arready = s_r.arready;
    assign s_rdata   = s_r.rdata;
    assign s_rresp   = s_r.rresp;
    assign s_rvalid  = s_r.rvalid;
    assign xb_req    = s_r.xreq;
    assign xb_we     = s_r.xwe;
    assign xb_ram    = s_r.xram;
    assign xb_byte   = s_r.xbyte;
    assign xb_addr   = s_r.xaddr;
    assign xb_wdata  = s_r.xwdata;
    assign chan_irq  = s_r.irq; // see RULE19

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    grant_lowest_a: assert property ( // see RULE22
        (s_r.st == ST_IDLE && |want) |=> s_r.cur == $past(pick(want)))
        else $error("grant not lowest channel");
    force_clear_a: assert property ( // see RULE21
        fin |=> !s_r.req[$past(s_r.cur)][B_FORCE])
        else $error("force bit survived transfer");
    oneshot_stop_a: assert property ( // see RULE23
        (fin && s_r.ctl[s_r.cur][B_MODE] && s_r.idx[s_r.cur] == s_r.cnt[s_r.cur])
        |=> !s_r.ctl[$past(s_r.cur)][B_EN])
        else $error("one-shot left channel enabled");
    block_len_a: assert property ( // see RULE20
        (fin && s_r.idx[s_r.cur] != s_r.cnt[s_r.cur])
        |=> s_r.idx[$past(s_r.cur)] == $past(s_r.idx[s_r.cur]) + 1'b1)
        else $error("transfer count not advanced");
    ptr_step_a: assert property ( // see RULE6
        (fin && s_r.ctl[s_r.cur][5:4] == 2'b00 && !s_r.ctl[s_r.cur][B_SIZE]
         && s_r.idx[s_r.cur] != s_r.cnt[s_r.cur])
        |=> s_r.ptr[$past(s_r.cur)] == $past(s_r.ptr[s_r.cur]) + 16'h0002)
        else $error("word pointer step wrong");
    pingpong_swap_a: assert property ( // see RULE9
        (fin && s_r.ctl[s_r.cur][1] && s_r.idx[s_r.cur] == s_r.cnt[s_r.cur])
        |=> s_r.pp[$past(s_r.cur)] != $past(s_r.pp[s_r.cur]))
        else $error("ping-pong buffer not swapped");
    dir_src_a: assert property ( // see RULE5
        (s_r.st == ST_RD && $past(s_r.st) == ST_IDLE)
        |-> s_r.xram == s_r.ctl[s_r.cur][B_DIR] && !s_r.xwe)
        else $error("source bus select wrong");
    irq_cause_a: assert property ( // see RULE7
        |s_r.irq |-> $past(s_r.st == ST_WR || s_r.st == ST_NUL) && $past(xb_ack))
        else $error("irq without finished transfer");
    bresp_due_a: assert property (
        (!s_r.awready && !s_r.wready && !s_r.bvalid) |=> s_r.bvalid)
        else $error("write response missing");
endmodule
`default_nettype wire

// ### verification/xb_peer.sv
`timescale 1ns/1ps
`default_nettype none
// Stand-in for RAM and peripheral registers on the transfer bus
module xb_peer (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        xb_req,
    input  wire logic        xb_we,
    input  wire logic        xb_ram,
    input  wire logic [15:0] xb_addr,
    input  wire logic [15:0] xb_wdata,
    output logic             xb_ack,
    output logic [15:0]      xb_rdata,
    output logic [15:0]      wr_addr,
    output logic [15:0]      wr_data,
    output logic [7:0]       wr_cnt
);
    logic [1:0] wait_r; // Cycles spent on the current phase
    // RAM answers promptly, peripherals two cycles later
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            xb_ack   <= 1'b0;
            wait_r   <= 2'd0;
            xb_rdata <= 16'h0000;
            wr_cnt   <= 8'h00;
        end else begin
            xb_ack <= xb_req && !xb_ack && (xb_ram || wait_r == 2'd2);
            wait_r <= (xb_ack || !xb_req) ? 2'd0 : wait_r + 2'd1;
            // Read data launched with ack; otherwise it keeps moving
            if (xb_req && !xb_ack && !xb_we
                && (xb_ram || wait_r == 2'd2)) begin
                xb_rdata <= xb_addr ^ 16'hA5C3;
            end else begin
                xb_rdata <= ~xb_rdata;
            end
            // Log each completed write phase
            if (xb_req && xb_ack && xb_we) begin
                wr_addr <= xb_addr;
                wr_data <= xb_wdata;
                wr_cnt  <= wr_cnt + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// ### verification/periph_dma_tb.sv
`timescale 1ns/1ps
`default_nettype none
module periph_dma_tb;
    import dma_pkg::*;
    logic         aclk      = 1'b0;
    logic         aresetn   = 1'b0;
    logic [8:0]   s_awaddr  = 9'h000;
    logic         s_awvalid = 1'b0;
    logic [31:0]  s_wdata   = 32'h0;
    logic         s_wvalid  = 1'b0;
    logic         s_bready  = 1'b0;
    logic [8:0]   s_araddr  = 9'h000;
    logic         s_arvalid = 1'b0;
    logic         s_rready  = 1'b0;
    logic [127:0] req_lines = 128'h0;
    logic [15:0]  pind_addr = 16'h0000;
    logic         ram_col   = 1'b0;
    logic         per_col   = 1'b0;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, xb_ack;
    logic xb_req, xb_we, xb_ram, xb_byte;
    logic [1:0]   s_bresp, s_rresp;
    logic [31:0]  s_rdata;
    logic [15:0]  xb_addr, xb_wdata, xb_rdata, wr_addr, wr_data;
    logic [7:0]   chan_irq, wr_cnt;
    logic [7:0]   irq_cnt [8]; // Interrupt pulses seen per channel
    logic         wr_byte;     // Size flag of the last logged write
    int           failures = 0;
    int           total_checks = 0;
    always #4 aclk = ~aclk;
    periph_dma periph_dma_inst (.aclk(aclk), .aresetn(aresetn),
        .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
        .s_wdata(s_wdata), .s_wstrb(4'h3), .s_wvalid(s_wvalid),
        .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
        .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
        .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
        .s_rvalid(s_rvalid), .s_rready(s_rready), .req_lines(req_lines),
        .pind_addr(pind_addr), .cpu_ram_collide(ram_col),
        .cpu_per_collide(per_col), .xb_req(xb_req), .xb_we(xb_we),
        .xb_ram(xb_ram), .xb_byte(xb_byte), .xb_addr(xb_addr),
        .xb_wdata(xb_wdata), .xb_ack(xb_ack), .xb_rdata(xb_rdata),
        .chan_irq(chan_irq));
    xb_peer xb_peer_inst (.aclk(aclk), .aresetn(aresetn), .xb_req(xb_req),
        .xb_we(xb_we), .xb_ram(xb_ram), .xb_addr(xb_addr),
        .xb_wdata(xb_wdata), .xb_ack(xb_ack), .xb_rdata(xb_rdata),
        .wr_addr(wr_addr), .wr_data(wr_data), .wr_cnt(wr_cnt));
    // Count interrupt pulses, one per cycle high
    always_ff @(posedge aclk) begin
        for (int i = 0; i < 8; i++) begin
            if (!aresetn) irq_cnt[i] <= 8'h00;
            else if (chan_irq[i] === 1'b1) irq_cnt[i] <= irq_cnt[i] + 8'h01;
        end
    end
    // Size flag of the last completed write phase
    always_ff @(posedge aclk) begin
        if (xb_req && xb_ack && xb_we) wr_byte <= xb_byte;
    end
    task automatic test_done();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [8:0] a(input int ch, input logic [4:0] o);
        return 9'(ch * 32) + {4'h0, o};
    endfunction
    // Write with address and data offered together, response awaited
    task automatic wr(input logic [8:0] ad, input logic [15:0] d,
                      input logic [1:0] rs);
        @(posedge aclk);
        s_awaddr  <= ad;
        s_wdata   <= {16'h0000, d};
        s_awvalid <= 1'b1;
        s_wvalid  <= 1'b1;
        s_bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_awready === 1'b1) s_awvalid <= 1'b0;
            if (s_wready === 1'b1) s_wvalid <= 1'b0;
        end while (s_bvalid !== 1'b1);
        s_bready <= 1'b0;
        chk({30'h0, s_bresp}, {30'h0, rs});
    endtask
    task automatic rd(input logic [8:0] ad, input logic [15:0] d,
                      input logic [1:0] rs);
        @(posedge aclk);
        s_araddr  <= ad;
        s_arvalid <= 1'b1;
        s_rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_arready === 1'b1) s_arvalid <= 1'b0;
        end while (s_rvalid !== 1'b1);
        s_rready <= 1'b0;
        chk(s_rdata, {16'h0000, d});
        chk({30'h0, s_rresp}, {30'h0, rs});
    endtask
    // Program a channel; enable goes last so setup is complete
    task automatic cfg(input int ch, input logic [15:0] ctl, rq, sa, sb,
                       pd, cn);
        wr(a(ch, OFS_REQ), rq, RESP_OKAY);
        wr(a(ch, OFS_STA), sa, RESP_OKAY);
        wr(a(ch, OFS_STB), sb, RESP_OKAY);
        wr(a(ch, OFS_PAD), pd, RESP_OKAY);
        wr(a(ch, OFS_CNT), cn, RESP_OKAY);
        wr(a(ch, OFS_CTL), ctl, RESP_OKAY);
    endtask
    task automatic pulse(input logic [127:0] m);
        @(posedge aclk);
        req_lines <= m;
        @(posedge aclk);
        req_lines <= 128'h0;
    endtask
    // Wait for a numbered write phase, bounded
    task automatic wait_wr(input logic [7:0] n, input logic [15:0] ea);
        int k;
        k = 0;
        do begin
            @(posedge aclk);
            k++;
        end while (wr_cnt < n && k < 200);
        repeat (2) @(posedge aclk);
        // A run-out limit shows up as a short count here
        chk({24'h0, wr_cnt}, {24'h0, n});
        chk({16'h0, wr_addr}, {16'h0, ea});
    endtask
    // Hang guard, far beyond the expected run length
    initial begin
        #300000;
        failures++;
        test_done();
    end
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rd(a(0, OFS_CTL), 16'h0000, RESP_OKAY);
        rd(OFS_PPST, 16'h0F00, RESP_OKAY);
        rd(9'h018, 16'h0000, RESP_SLVERR);
        wr(9'h018, 16'hFFFF, RESP_SLVERR);
        wr(a(7, OFS_CTL), 16'h07CC, RESP_OKAY);
        rd(a(7, OFS_CTL), 16'h0000, RESP_OKAY);
        wr(a(7, OFS_CNT), 16'hFFFF, RESP_OKAY);
        rd(a(7, OFS_CNT), 16'h03FF, RESP_OKAY);
        pulse(128'h1);
        repeat (10) @(posedge aclk);
        chk({24'h0, wr_cnt}, 32'h0);
        $display("test registers done");
        // One-shot, word, peripheral to RAM, post-increment
        cfg(1, 16'h8001, 16'h000B, 16'h0100, 16'h0000, 16'h0226, 16'h0001);
        pulse(128'h1 << 11);
        wait_wr(8'd1, 16'h0100);
        chk({16'h0, wr_data}, 32'h0000A7E5);
        chk({31'h0, wr_byte}, 32'h0);
        rd(a(1, OFS_STA), 16'h0102, RESP_OKAY);
        ram_col <= 1'b1;
        pulse(128'h1 << 11);
        wait_wr(8'd2, 16'h0102);
        ram_col <= 1'b0;
        chk({24'h0, irq_cnt[1]}, 32'h1);
        rd(a(1, OFS_CTL), 16'h0001, RESP_OKAY);
        rd(a(1, OFS_STA), 16'h0100, RESP_OKAY);
        rd(OFS_COLL, 16'h0002, RESP_OKAY);
        wr(OFS_COLL, 16'h0002, RESP_OKAY);
        rd(OFS_COLL, 16'h0000, RESP_OKAY);
        $display("test one-shot done");
        // Forced byte, RAM to peripheral, peripheral-supplied address
        pind_addr <= 16'h0480;
        per_col <= 1'b1;
        cfg(2, 16'hE020, 16'h0000, 16'h0000, 16'h0000, 16'h0224, 16'h0000);
        wr(a(2, OFS_REQ), 16'h8000, RESP_OKAY);
        wait_wr(8'd3, 16'h0224);
        per_col <= 1'b0;
        chk({16'h0, wr_data}, 32'h00000043);
        chk({31'h0, wr_byte}, 32'h1);
        rd(a(2, OFS_REQ), 16'h0000, RESP_OKAY);
        repeat (10) @(posedge aclk);
        chk({24'h0, wr_cnt}, 32'h3);
        rd(OFS_COLL, 16'h0400, RESP_OKAY);
        $display("test force done");
        // Two channels triggered together, fixed addressing on one
        cfg(4, 16'h8001, 16'h0006, 16'h0700, 16'h0000, 16'h0188, 16'h0000);
        cfg(3, 16'h8011, 16'h0005, 16'h0600, 16'h0000, 16'h0144, 16'h0001);
        pulse(128'h3 << 5);
        wait_wr(8'd4, 16'h0600);
        wait_wr(8'd5, 16'h0700);
        rd(OFS_PPST, 16'h0400, RESP_OKAY);
        rd(a(4, OFS_CTL), 16'h0001, RESP_OKAY);
        pulse(128'h1 << 5);
        wait_wr(8'd6, 16'h0600);
        $display("test priority done");
        // Continuous ping-pong with half-block interrupt
        cfg(5, 16'h9002, 16'h001E, 16'h0200, 16'h0300, 16'h0236, 16'h0001);
        pulse(128'h1 << 30);
        wait_wr(8'd7, 16'h0200);
        chk({24'h0, irq_cnt[5]}, 32'h1);
        pulse(128'h1 << 30);
        wait_wr(8'd8, 16'h0202);
        chk({24'h0, irq_cnt[5]}, 32'h1);
        pulse(128'h1 << 30);
        wait_wr(8'd9, 16'h0300);
        chk({24'h0, irq_cnt[5]}, 32'h2);
        rd(OFS_PPST, 16'h0520, RESP_OKAY);
        rd(a(5, OFS_STB), 16'h0302, RESP_OKAY);
        $display("test ping-pong done");
        // Null write follows the RAM write, peripheral to RAM
        cfg(6, 16'h8801, 16'h000D, 16'h0400, 16'h0000, 16'h0300, 16'h0000);
        pulse(128'h1 << 13);
        wait_wr(8'd10, 16'h0400);
        wait_wr(8'd11, 16'h0300);
        chk({16'h0, wr_data}, 32'h0);
        rd(a(6, OFS_CTL), 16'h0801, RESP_OKAY);
        $display("test null write done");
        test_done();
    end
endmodule
`default_nettype wire
